// file: core/phy_irq_cfg.svh
`ifndef PHY_IRQ_CFG_SVH
`define PHY_IRQ_CFG_SVH
// ***************************************************
// Register indices (byte address is four times the index)
// ***************************************************
`define REG_IDX_MASK_ENABLE   8'h12
`define REG_IDX_EVENT_CHANGE  8'h13
`define REG_IDX_STATUS_IN     8'h14
// ***************************************************
// Field positions
// ***************************************************
`define BIT_AUTONEG           7
`define BIT_SPEED             6
`define BIT_DUPLEX            5
`define BIT_LINK              4
`define BIT_PENDING           2
`define BIT_GLOBAL_EN         1
`define BIT_TEST_FORCE        0
`define MASK_ENABLE_WMASK     16'h00F3
`define MASK_ENABLE_RESET     16'h0000
// ***************************************************
// Timing
// ***************************************************
`define EDGE_ARM_DEPTH        3
`endif

// file: core/phy_irq_pkg.sv
`default_nettype none
package phy_irq_pkg;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_DONE = 2'b01
   } bus_state_t;
endpackage : phy_irq_pkg
`default_nettype wire

// file: core/phy_mgmt_interrupt_logic.sv
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "phy_irq_cfg.svh"

module phy_mgmt_interrupt_logic (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest,
   input  wire logic        autoneg_done_in,
   input  wire logic        speed_in,
   input  wire logic        duplex_in,
   input  wire logic        link_in,
   output var  logic        mgmt_irq_n
);

   // ***************************************************
   // Status input synchronisers
   // ***************************************************
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [3:0] prev_q;
   logic [`EDGE_ARM_DEPTH-1:0] prev_valid_q;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_q      <= 4'h0;
         sync2_q      <= 4'h0;
         prev_q       <= 4'h0;
         prev_valid_q <= {`EDGE_ARM_DEPTH{1'b0}};
      end else begin
         sync1_q      <= {autoneg_done_in, speed_in, duplex_in, link_in};
         sync2_q      <= sync1_q;
         prev_q       <= sync2_q;
         prev_valid_q <= {prev_valid_q[`EDGE_ARM_DEPTH-2:0], 1'b1};
      end
   end

   // Edges count only once the previous-sample stage holds a real pin sample; an earlier
   // compare against reset zeros would set a flag for every pin that idles high
   wire        edge_armed = prev_valid_q[`EDGE_ARM_DEPTH-1];
   wire        speed_evt  = edge_armed & (sync2_q[2] ^ prev_q[2]);
   wire        duplex_evt = edge_armed & (sync2_q[1] ^ prev_q[1]);
   wire        link_evt   = edge_armed & (sync2_q[0] ^ prev_q[0]);
   wire        autoneg_done_flag = sync2_q[3];

   // ***************************************************
   // Avalon-MM slave
   // ***************************************************
   phy_irq_pkg::bus_state_t bus_q;
   logic [15:0] mask_enable_q;
   logic        speed_changed_flag_q;
   logic        duplex_changed_flag_q;
   logic        link_changed_flag_q;

   wire req        = avs_read | avs_write;
   wire accept     = req & (bus_q == phy_irq_pkg::BUS_IDLE);
   wire hit_mask   = (avs_address == `REG_IDX_MASK_ENABLE);
   wire hit_change = (avs_address == `REG_IDX_EVENT_CHANGE);
   wire hit_status = (avs_address == `REG_IDX_STATUS_IN);
   wire wr_mask    = accept & avs_write & hit_mask;
   wire rd_change  = accept & avs_read & hit_change;

   wire [15:0] wmask     = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & `MASK_ENABLE_WMASK;
   wire [15:0] mask_d    = (mask_enable_q & ~wmask) | (avs_writedata[15:0] & wmask);

   wire autoneg_done_mask = mask_enable_q[`BIT_AUTONEG];
   wire speed_event_mask  = mask_enable_q[`BIT_SPEED];
   wire duplex_event_mask = mask_enable_q[`BIT_DUPLEX];
   wire link_event_mask   = mask_enable_q[`BIT_LINK];
   wire global_irq_enable = mask_enable_q[`BIT_GLOBAL_EN];
   wire test_force_irq    = mask_enable_q[`BIT_TEST_FORCE];

   // Event set wins over a read clear in the same cycle
   wire speed_flag_d  = speed_evt  | (speed_changed_flag_q  & ~rd_change);
   wire duplex_flag_d = duplex_evt | (duplex_changed_flag_q & ~rd_change);
   wire link_flag_d   = link_evt   | (link_changed_flag_q   & ~rd_change);

   wire masked_any = (autoneg_done_flag    & autoneg_done_mask)
                   | (speed_changed_flag_q  & speed_event_mask)
                   | (duplex_changed_flag_q & duplex_event_mask)
                   | (link_changed_flag_q   & link_event_mask);
   wire irq_d      = test_force_irq | (global_irq_enable & masked_any);
   logic irq_q;

   wire [15:0] change_view = {8'h00, autoneg_done_flag, speed_changed_flag_q, duplex_changed_flag_q,
                              link_changed_flag_q, 1'b0, irq_q, 2'b00};
   wire [31:0] rdata_d = hit_mask   ? {16'h0000, mask_enable_q}
                       : hit_change ? {16'h0000, change_view}
                       : hit_status ? {28'h0000000, sync2_q}
                       : 32'h00000000;

   // One wait cycle, then the answer; unmapped reads return zero, writes drop
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bus_q           <= phy_irq_pkg::BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else begin
         bus_q           <= accept ? phy_irq_pkg::BUS_DONE : phy_irq_pkg::BUS_IDLE;
         avs_waitrequest <= ~accept;
         avs_readdata    <= (accept & avs_read) ? rdata_d : 32'h00000000;
      end
   end

   // ***************************************************
   // Mask and enable register
   // ***************************************************
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mask_enable_q <= `MASK_ENABLE_RESET;
      end else if (wr_mask) begin
         mask_enable_q <= mask_d;
      end
   end

   // ***************************************************
   // Change flags
   // ***************************************************
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         speed_changed_flag_q  <= 1'b0;
         duplex_changed_flag_q <= 1'b0;
         link_changed_flag_q   <= 1'b0;
      end else begin
         speed_changed_flag_q  <= speed_flag_d;
         duplex_changed_flag_q <= duplex_flag_d;
         link_changed_flag_q   <= link_flag_d;
      end
   end

   // ***************************************************
   // Interrupt output
   // ***************************************************
   // Pending bit and pin share one next value, so software never sees them disagree
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irq_q      <= 1'b0;
         mgmt_irq_n <= 1'b1;
      end else begin
         irq_q      <= irq_d;
         mgmt_irq_n <= ~irq_d;
      end
   end

   // ***************************************************
   // Assertions
   // ***************************************************
   sequence s_read_change;
      rd_change && !speed_evt;
   endsequence

   a_force_irq_low: assert property (@(posedge sys_clk) disable iff (!resetn)
      test_force_irq |=> !mgmt_irq_n) else $error("test force did not assert interrupt");
   a_global_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!global_irq_enable && !test_force_irq) |=> mgmt_irq_n) else $error("interrupt without global enable");
   a_speed_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
      (speed_changed_flag_q && !rd_change) |=> speed_changed_flag_q) else $error("speed flag lost");
   a_speed_set: assert property (@(posedge sys_clk) disable iff (!resetn)
      speed_evt |=> speed_changed_flag_q) else $error("speed flag not set");
   a_duplex_set: assert property (@(posedge sys_clk) disable iff (!resetn)
      duplex_evt |=> duplex_changed_flag_q) else $error("duplex flag not set");
   a_link_set: assert property (@(posedge sys_clk) disable iff (!resetn)
      link_evt |=> link_changed_flag_q) else $error("link flag not set");
   a_read_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_read_change |=> !speed_changed_flag_q) else $error("read did not clear speed flag");
   a_link_masked: assert property (@(posedge sys_clk) disable iff (!resetn)
      (link_changed_flag_q && link_event_mask && global_irq_enable) |=> !mgmt_irq_n)
      else $error("masked link change gave no interrupt");
   a_pending_match: assert property (@(posedge sys_clk) disable iff (!resetn)
      rd_change |=> (avs_readdata[`BIT_PENDING] == !$past(mgmt_irq_n)))
      else $error("pending bit disagrees with output");
   a_bus_answer: assert property (@(posedge sys_clk) disable iff (!resetn)
      (req && avs_waitrequest && bus_q == phy_irq_pkg::BUS_IDLE) |=> !avs_waitrequest)
      else $error("bus answer late");

   // ***************************************************
   // Bus assertions
   // ***************************************************
   sequence s_change_taken;
      accept && avs_read && hit_change;
   endsequence

   sequence s_mask_taken;
      accept && avs_read && hit_mask;
   endsequence

   sequence s_write_elsewhere;
      accept && avs_write && !hit_mask;
   endsequence

   a_wait_single: assert property (@(posedge sys_clk) disable iff (!resetn)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer held too long");

   a_readdata_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
      avs_waitrequest |-> (avs_readdata == 32'h0000_0000))
      else $error("read data outside the answer cycle");

   a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
      (accept && avs_read && !hit_mask && !hit_change && !hit_status) |=> (avs_readdata == 32'h0000_0000))
      else $error("unmapped read not zero");

   a_mask_readback: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_mask_taken |=> (avs_readdata == {16'h0000, $past(mask_enable_q)}))
      else $error("mask register read back wrong");

   a_mask_write: assert property (@(posedge sys_clk) disable iff (!resetn)
      (wr_mask && avs_byteenable[0]) |=> (mask_enable_q[7:0] == ($past(avs_writedata[7:0]) & 8'hF3)))
      else $error("mask register write lost");

   a_write_keeps_mask: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_write_elsewhere |=> $stable(mask_enable_q))
      else $error("foreign write changed mask register");

   a_mask_reserved: assert property (@(posedge sys_clk) disable iff (!resetn)
      (mask_enable_q & ~`MASK_ENABLE_WMASK) == 16'h0000)
      else $error("reserved mask bit stored");

   // ***************************************************
   // Flag assertions
   // ***************************************************
   a_duplex_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
      (duplex_changed_flag_q && !rd_change) |=> duplex_changed_flag_q)
      else $error("duplex flag lost");

   a_link_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
      (link_changed_flag_q && !rd_change) |=> link_changed_flag_q)
      else $error("link flag lost");

   a_speed_cause: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!speed_changed_flag_q && !speed_evt) |=> !speed_changed_flag_q)
      else $error("speed flag set without change");

   a_duplex_cause: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!duplex_changed_flag_q && !duplex_evt) |=> !duplex_changed_flag_q)
      else $error("duplex flag set without change");

   a_link_cause: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!link_changed_flag_q && !link_evt) |=> !link_changed_flag_q)
      else $error("link flag set without change");

   a_duplex_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
      (rd_change && !duplex_evt) |=> !duplex_changed_flag_q)
      else $error("read did not clear duplex flag");

   a_link_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
      (rd_change && !link_evt) |=> !link_changed_flag_q)
      else $error("read did not clear link flag");

   a_change_view: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_change_taken |=> (avs_readdata[`BIT_AUTONEG] == $past(autoneg_done_flag)))
      else $error("negotiation done bit read wrong");

   a_flags_view: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_change_taken |=> (avs_readdata[`BIT_SPEED:`BIT_LINK] == $past({speed_changed_flag_q, duplex_changed_flag_q, link_changed_flag_q})))
      else $error("change flags read wrong");

   a_change_reserved: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_change_taken |=> (avs_readdata[31:8] == 24'h000000 && !avs_readdata[3] && avs_readdata[1:0] == 2'h0))
      else $error("reserved change bits not zero");

   // ***************************************************
   // Interrupt assertions
   // ***************************************************
   a_autoneg_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
      (autoneg_done_flag && autoneg_done_mask && global_irq_enable) |=> !mgmt_irq_n)
      else $error("masked negotiation done gave no interrupt");

   a_speed_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
      (speed_changed_flag_q && speed_event_mask && global_irq_enable) |=> !mgmt_irq_n)
      else $error("masked speed change gave no interrupt");

   a_duplex_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
      (duplex_changed_flag_q && duplex_event_mask && global_irq_enable) |=> !mgmt_irq_n)
      else $error("masked duplex change gave no interrupt");

   a_masks_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!test_force_irq && !(autoneg_done_flag && autoneg_done_mask)
       && !(speed_changed_flag_q && speed_event_mask) && !(duplex_changed_flag_q && duplex_event_mask)
       && !(link_changed_flag_q && link_event_mask)) |=> mgmt_irq_n)
      else $error("interrupt without a masked cause");

   a_reset_quiet: assert property (@(posedge sys_clk)
      !resetn |=> (mgmt_irq_n && avs_waitrequest && mask_enable_q == `MASK_ENABLE_RESET
                   && !speed_changed_flag_q && !duplex_changed_flag_q && !link_changed_flag_q))
      else $error("reset left state set");

endmodule : phy_mgmt_interrupt_logic
`default_nettype wire

// file: verif/mgmt_master.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// Avalon master standing in for the management controller
// ****************************************************
module mgmt_master (
   input  wire logic        sys_clk,
   output var  logic [7:0]  avs_address,
   output var  logic        avs_read,
   output var  logic        avs_write,
   output var  logic [31:0] avs_writedata,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   initial begin
      avs_address   = 8'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0000_0000;
   end
   // Request held until waitrequest is seen low, so a slow answer never truncates it
   task automatic xfer(input logic is_wr, input logic [7:0] adr, input logic [15:0] wd, output logic [31:0] rd);
      @(posedge sys_clk);
      avs_address   <= adr;
      avs_read      <= ~is_wr;
      avs_write     <= is_wr;
      avs_writedata <= {16'h0000, wd & 16'h00F3};
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : xfer
endmodule : mgmt_master
`default_nettype wire

// file: verif/phy_mgmt_interrupt_logic_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// Self-checking bench
// ****************************************************
module phy_mgmt_interrupt_logic_bench;
   logic        sys_clk   = 1'b0;
   logic        resetn    = 1'b0;
   logic [7:0]  adr;
   logic        rd_s;
   logic        wr_s;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        wreq;
   logic [3:0]  st        = 4'h0;
   logic        irq_n;
   logic [31:0] junk;
   logic [31:0] exp_q[$];
   int          err_total = 0;
   int          cmp_count = 0;
   always #12.5 sys_clk = ~sys_clk;
   phy_mgmt_interrupt_logic dut_u (.sys_clk(sys_clk), .resetn(resetn), .avs_address(adr), .avs_read(rd_s),
      .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq),
      .autoneg_done_in(st[3]), .speed_in(st[2]), .duplex_in(st[1]), .link_in(st[0]), .mgmt_irq_n(irq_n));
   mgmt_master host_u (.sys_clk(sys_clk), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
      .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      host_u.xfer(1'b0, a, 16'h0000, junk);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      host_u.xfer(1'b1, a, d, junk);
   endtask : wr
   // Interrupt settles one cycle after its cause; three cycles leave margin
   task automatic irq(input logic e);
      repeat (3) @(posedge sys_clk);
      chk({31'h0, irq_n}, {31'h0, e});
   endtask : irq
   task automatic print_verdict;
      if (err_total == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict
   always @(posedge sys_clk) begin
      if (rd_s && wreq === 1'b0) begin
         chk(rdat, (exp_q.size() > 0) ? exp_q.pop_front() : 32'hXXXX_XXXX);
      end
   end
   initial begin
      #100000;
      err_total++;
      print_verdict();
   end
   initial begin
      void'($urandom(42385));
      @(posedge sys_clk);
      st <= {1'b0, 3'($urandom)};
      repeat (7) @(posedge sys_clk);
      resetn <= 1'b1;
      irq(1'b1);
      rd(8'h12, 32'h0000_0000);
      rd(8'h13, 32'h0000_0000);
      rd(8'h20, 32'h0000_0000);
      wr(8'h12, 16'h0001);
      irq(1'b0);
      rd(8'h13, 32'h0000_0004);
      wr(8'h12, 16'h0000);
      irq(1'b1);
      for (int b = 4; b < 7; b++) begin
         st[b - 4] <= ~st[b - 4];
         repeat (8) @(posedge sys_clk);
         wr(8'h12, 16'h0001 << b);
         irq(1'b1);
         wr(8'h13, 16'h0000);
         wr(8'h12, 16'h0001 << b | 16'h0002);
         irq(1'b0);
         rd(8'h12, 32'h0000_0001 << b | 32'h0000_0002);
         rd(8'h13, 32'h0000_0001 << b | 32'h0000_0004);
         irq(1'b1);
         rd(8'h13, 32'h0000_0000);
      end
      st[3] <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rd(8'h13, 32'h0000_0080);
      wr(8'h12, 16'h0082);
      irq(1'b0);
      wr(8'h12, 16'h0002);
      irq(1'b1);
      // Mid-run reset with pins away from zero must not fake change events
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (8) @(posedge sys_clk);
      irq(1'b1);
      rd(8'h12, 32'h0000_0000);
      rd(8'h13, 32'h0000_0080);
      repeat (2) @(posedge sys_clk);
      print_verdict();
   end
endmodule : phy_mgmt_interrupt_logic_bench
`default_nettype wire
